//--- design/uft_xcvr_cfg.sv
// Transceiver control, pull-up steering and endpoint address map
`timescale 1ns/1ns
`include "uft_cfg.svh"
module uft_xcvr_cfg (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vbus_detect,
	input  wire logic        usb_clk_running,
	input  wire logic        line_dp_in,
	input  wire logic        line_dn_in,
	input  wire logic        line_diff_in,
	input  wire logic [7:0]  token_ep_addr,
	output logic             token_ep_valid,
	output logic [2:0]       token_pipe,
	output logic             xcvr_enable,
	output logic             pullup_dp,
	output logic             pullup_dn,
	output logic             full_speed,
	output logic             force_dp,
	output logic             force_dn,
	output logic             force_en,
	output logic             host_mode
);
	localparam logic [7:0] XCN_RST = `UFT_XCN_RESET;

	logic [7:0]         xcn_q;
	logic               pu_en_q;
	logic               pu_en_d;
	logic               phy_on_q;
	logic               phy_on_d;
	logic               speed_q;
	logic               speed_d;
	logic [1:0]         tst_q;
	logic [1:0]         tst_d;
	logic               clk_en_q;
	logic               clk_en_d;

	logic               acc;
	logic               setup_rd;
	logic               wr_xcn;
	logic               wr_clk;
	logic [1:0]         reg_sel;
	logic               addr_ok;

	logic [7:0]         status;
	logic [31:0]        rd_d;
	logic [31:0]        rd_q;

	logic [6:0]         pipe_hit;
	logic               ep_ok_d;
	logic [2:0]         pipe_d;

	logic               clk_ok;
	logic               xcvr_d;
	logic               pull_dp_d;
	logic               pull_dn_d;
	logic [2:0]         force_d;
	uft_pkg::uft_test_t tst;

	// Register select: 0 unmapped, 1 control, 2 clock enable, 3 endpoint info
	function automatic logic [1:0] uft_reg_sel(input logic [11:0] a);
		logic [1:0] s;
		s = 2'h0;
		if (a == `UFT_XCN_ADDR) begin
			s = 2'h1;
		end else if (a == `UFT_CLKCTL_ADDR) begin
			s = 2'h2;
		end else if (a == `UFT_EPMAP_ADDR) begin
			s = 2'h3;
		end
		uft_reg_sel = s;
	endfunction

	// Protocol address of pipe p: 0 is endpoint zero, odd pipes IN, even pipes OUT
	function automatic logic [7:0] uft_pipe_addr(input logic [2:0] p);
		logic [2:0] n;
		logic [7:0] a;
		n = 3'((4'(p) + 4'h1) >> 1);
		a = {6'h00, n[1:0]};
		if (p == 3'h0) begin
			a = `UFT_EP0_ADDR; // R2
		end else if (p[0]) begin
			a = a | `UFT_EP_IN_FLAG; // R3
		end
		uft_pipe_addr = a;
	endfunction

	// Force pattern {enable, D+, D-}; reserved code behaves as normal
	function automatic logic [2:0] uft_force(input uft_pkg::uft_test_t t);
		logic [2:0] f;
		f = 3'b000;
		case (t)
			uft_pkg::UFT_TST_FORCE1: begin
				f = 3'b110; // R10
			end
			uft_pkg::UFT_TST_FORCE0: begin
				f = 3'b101; // R10
			end
			uft_pkg::UFT_TST_NORMAL: begin
				f = 3'b000; // R10
			end
			default: begin
				f = 3'b000;
			end
		endcase
		uft_force = f;
	endfunction

	assign acc      = psel && penable;
	assign setup_rd = psel && !penable && !pwrite;
	assign reg_sel  = uft_reg_sel(paddr);
	assign addr_ok  = reg_sel != 2'h0;
	assign wr_xcn   = acc && pwrite && reg_sel == 2'h1;
	assign wr_clk   = acc && pwrite && reg_sel == 2'h2;
	assign pready   = 1'b1;
	assign pslverr  = acc && !addr_ok;

	// Bits 2..0 are live status, never stored
	assign pu_en_d  = wr_xcn ? pwdata[`UFT_PULLUP_EN_BIT] : pu_en_q; // R4
	assign phy_on_d = wr_xcn ? pwdata[`UFT_PHY_ON_BIT] : phy_on_q; // R4
	assign speed_d  = wr_xcn ? pwdata[`UFT_SPEED_BIT] : speed_q; // R4
	assign tst_d    = wr_xcn ? pwdata[`UFT_TST_HI:`UFT_TST_LO] : tst_q; // R8
	assign clk_en_d = wr_clk ? pwdata[0] : clk_en_q;

	assign xcn_q   = {pu_en_q, phy_on_q, speed_q, tst_q, 3'b000};
	assign tst     = uft_pkg::uft_test_t'(tst_q);
	assign clk_ok  = clk_en_q && usb_clk_running;
	assign force_d = uft_force(tst);
	// VBUS gates the pull-up every cycle, so a lost VBUS drops it on the next pclk edge
	assign xcvr_d    = phy_on_q && clk_ok; // R11
	assign pull_dp_d = pu_en_q && vbus_detect && speed_q; // R5 R7 R12
	assign pull_dn_d = pu_en_q && vbus_detect && !speed_q; // R6 R7 R12

	// Live line status bits are read only
	assign status = {5'h00, line_diff_in, line_dp_in, line_dn_in}; // R8

	genvar gi;
	generate
		for (gi = 0; gi < `UFT_PIPE_COUNT; gi++) begin : g_pipe
			assign pipe_hit[gi] = token_ep_addr == uft_pipe_addr(3'(gi)); // R2 R3
		end
	endgenerate

	always_comb begin
		ep_ok_d = 1'b0;
		pipe_d  = 3'h0;
		for (int i = 0; i < `UFT_PIPE_COUNT; i++) begin
			if (pipe_hit[i]) begin
				ep_ok_d = 1'b1;
				pipe_d  = 3'(i);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_en_q <= XCN_RST[`UFT_PULLUP_EN_BIT];
		end else begin
			pu_en_q <= pu_en_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_on_q <= XCN_RST[`UFT_PHY_ON_BIT];
		end else begin
			phy_on_q <= phy_on_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_q <= XCN_RST[`UFT_SPEED_BIT];
		end else begin
			speed_q <= speed_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tst_q <= XCN_RST[`UFT_TST_HI:`UFT_TST_LO];
		end else begin
			tst_q <= tst_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_en_q <= 1'b0;
		end else begin
			clk_en_q <= clk_en_d;
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_sel == 2'h1) begin
			rd_d = {24'h000000, xcn_q | status}; // R8
		end else if (reg_sel == 2'h2) begin
			rd_d = {30'h0000_0000, usb_clk_running, clk_en_q};
		end else if (reg_sel == 2'h3) begin
			rd_d = {24'h000000, 4'(`UFT_EP_COUNT), 4'h0};
		end
	end

	// Taken at setup so the word stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			rd_q <= rd_d;
		end
	end
	assign prdata = rd_q;

	// Registered so pipe index and valid flag line up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			token_ep_valid <= 1'b0;
		end else begin
			token_ep_valid <= ep_ok_d; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			token_pipe <= 3'h0;
		end else begin
			token_pipe <= pipe_d; // R3
		end
	end

	// Enable only takes effect while the USB clock runs, guarding firmware order slips
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xcvr_enable <= 1'b0;
		end else begin
			xcvr_enable <= xcvr_d; // R11
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_speed <= 1'b0;
		end else begin
			full_speed <= speed_q; // R5 R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_dp <= 1'b0;
		end else begin
			pullup_dp <= pull_dp_d; // R5 R7 R12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_dn <= 1'b0;
		end else begin
			pullup_dn <= pull_dn_d; // R6 R7 R12
		end
	end

	// Registered so the forced line drive never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_en <= 1'b0;
		end else begin
			force_en <= force_d[2]; // R10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_dp <= 1'b0;
		end else begin
			force_dp <= force_d[1]; // R10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_dn <= 1'b0;
		end else begin
			force_dn <= force_d[0]; // R10
		end
	end

	// Function role only
	assign host_mode = 1'b0; // R1
endmodule // uft_xcvr_cfg

//--- design/uft_cfg.svh
// Constants for the USB function transceiver configuration block
// Notes on behaviour
// R1: The block is a USB peripheral function only, never a bus host.
// R2: Endpoint zero is one bidirectional pipe at address 0x00.
// R3: Endpoints one to three: IN pipes at 0x81-0x83, OUT pipes at 0x01-0x03.
// R4: Transceiver control holds enable, pull-up enable and speed select.
// R5: Speed one means full speed, pull-up on D+.
// R6: Speed zero means low speed, pull-up on D-.
// R7: Pull-up connects only while VBUS is detected.
// R8: Low five bits serve test: forcing lines and reading line status.
// R9: Firmware starts the USB clock before setting transceiver enable.
// R10: Test field 00 normal, 01 forced one, 10 forced zero.
// R11: Physical layer enable switches the transceiver on or off.
// R12: Losing VBUS drops the pull-up; it returns with VBUS if enabled.
`ifndef UFT_CFG_SVH
`define UFT_CFG_SVH

`define UFT_XCN_ADDR      12'h000
`define UFT_CLKCTL_ADDR   12'h004
`define UFT_EPMAP_ADDR    12'h008
`define UFT_XCN_RESET     8'h00
`define UFT_PULLUP_EN_BIT 7
`define UFT_PHY_ON_BIT    6
`define UFT_SPEED_BIT     5
`define UFT_TST_HI        4
`define UFT_TST_LO        3
`define UFT_DFREC_BIT     2
`define UFT_DP_BIT        1
`define UFT_DN_BIT        0
`define UFT_WR_MASK       8'hF8
`define UFT_EP_IN_FLAG    8'h80
`define UFT_EP_COUNT      4
`define UFT_EP0_ADDR      8'h00
`define UFT_PIPE_COUNT    7

`endif

//--- design/uft_pkg.sv
// Types for the USB function transceiver configuration block
package uft_pkg;
	typedef enum logic [1:0] {
		UFT_TST_NORMAL = 2'b00,
		UFT_TST_FORCE1 = 2'b01,
		UFT_TST_FORCE0 = 2'b10,
		UFT_TST_RSVD   = 2'b11
	} uft_test_t;
endpackage

//--- test/uft_host_model.sv
// Host end of the cable: VBUS and line levels
`timescale 1ns/1ns
module uft_host_model (
	input  wire logic vbus_on,
	input  wire logic pullup_dp,
	input  wire logic pullup_dn,
	output logic      vbus_detect,
	output logic      line_dp_in,
	output logic      line_dn_in,
	output logic      line_diff_in
);
	assign vbus_detect = vbus_on;
	// Host pull-downs hold a line low unless pulled up
	assign line_dp_in = pullup_dp;
	assign line_dn_in = pullup_dn;
	assign line_diff_in = pullup_dp & ~pullup_dn;
endmodule // uft_host_model

//--- test/uft_cfg_monitor.sv
// Checker for the transceiver configuration ports
`timescale 1ns/1ns
module uft_cfg_monitor (
	input wire logic        pclk, presetn, psel, penable, pwrite, vbus_detect, usb_clk_running, token_ep_valid,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0]  token_ep_addr,
	input wire logic [2:0]  token_pipe,
	input wire logic        xcvr_enable, pullup_dp, pullup_dn, full_speed, force_en, force_dp, force_dn, host_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hm; !host_mode; endproperty
	a_hm: assert property (p_hm) else $error("host");
	property p_e0; token_ep_addr == 8'h00 |=> token_ep_valid && token_pipe == 3'h0; endproperty
	a_e0: assert property (p_e0) else $error("ep0");
	property p_e3; token_ep_addr == 8'h83 |=> token_ep_valid && token_pipe == 3'h5; endproperty
	a_e3: assert property (p_e3) else $error("ep3");
	property p_wr; psel && penable && pwrite && paddr == 12'h000 |-> ##2 full_speed == $past(pwdata[5], 2); endproperty
	a_wr: assert property (p_wr) else $error("speed");
	property p_fs; pullup_dp |-> full_speed && !pullup_dn; endproperty
	a_fs: assert property (p_fs) else $error("dp");
	property p_ls; pullup_dn |-> !full_speed; endproperty
	a_ls: assert property (p_ls) else $error("dn");
	property p_vb; !vbus_detect |=> !pullup_dp && !pullup_dn; endproperty
	a_vb: assert property (p_vb) else $error("vbus");
	property p_tm; force_en |-> force_dp != force_dn; endproperty
	a_tm: assert property (p_tm) else $error("force");
	property p_en; !usb_clk_running |=> !xcvr_enable; endproperty
	a_en: assert property (p_en) else $error("enable");
endmodule // uft_cfg_monitor
bind uft_xcvr_cfg uft_cfg_monitor u_mon (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.vbus_detect(vbus_detect),
	.usb_clk_running(usb_clk_running),
	.token_ep_valid(token_ep_valid),
	.paddr(paddr),
	.pwdata(pwdata),
	.token_ep_addr(token_ep_addr),
	.token_pipe(token_pipe),
	.xcvr_enable(xcvr_enable),
	.pullup_dp(pullup_dp),
	.pullup_dn(pullup_dn),
	.full_speed(full_speed),
	.force_en(force_en),
	.force_dp(force_dp),
	.force_dn(force_dn),
	.host_mode(host_mode)
);

//--- test/testbench.sv
// Testbench for the transceiver configuration block
`timescale 1ns/1ns
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vbus_on = 0, usb_clk_running = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [7:0]  token_ep_addr = 0;
	logic        pready, pslverr, err, vbus_detect, line_dp_in, line_dn_in, line_diff_in, token_ep_valid;
	logic        xcvr_enable, pullup_dp, pullup_dn, full_speed, force_en, force_dp, force_dn, host_mode;
	logic [2:0]  token_pipe;
	int          mismatches = 0, total_checks = 0, n;
	wire  [6:0]  o = {xcvr_enable, pullup_dp, pullup_dn, full_speed, force_en, force_dp, force_dn};
	uft_xcvr_cfg u_dut (.*);
	uft_host_model u_host (.*);
	initial forever #2 pclk = ~pclk;
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(string s, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do @(posedge pclk); while (pready !== 1 && ++n < 99);
		if (n >= 99) begin
			mismatches++;
			give_verdict;
		end else begin
			r = prdata;
			err = pslverr;
			{psel, penable} <= 0;
			repeat (2) @(posedge pclk);
			#1;
		end
	endtask
	task t_regs;
		apb(0, 12'h000, 0);
		chk("ctl", 0, r);
		apb(0, 12'h00C, 0);
		chk("slverr", 1, err);
		chk("ready", 1, pready);
		chk("host", 0, host_mode);
		apb(0, 12'h008, 0);
		chk("info", 32'h40, r);
	endtask
	task t_speed;
		apb(1, 12'h004, 1);
		apb(1, 12'h000, 32'hE7);
		chk("full", 7'h68, o);
		apb(0, 12'h000, 0);
		chk("ctl", 32'hE6, r);
		apb(0, 12'h004, 0);
		chk("clkctl", 3, r);
		apb(1, 12'h000, 32'hC0);
		chk("low", 7'h50, o);
		@(posedge pclk);
		vbus_on <= 0;
		repeat (3) @(posedge pclk);
		#1;
		chk("novbus", 7'h40, o);
		vbus_on <= 1;
		repeat (3) @(posedge pclk);
		#1;
		chk("vbus", 7'h50, o);
	endtask
	task t_test;
		logic [2:0] fx[4] = '{0, 6, 5, 0};
		for (int t = 0; t < 4; t++) begin
			apb(1, 12'h000, 32'hC0 | t << 3);
			chk("test", 7'h50 | fx[t], o);
		end
	endtask
	task t_tok;
		logic [7:0] ea[8] = '{8'h00, 8'h81, 8'h01, 8'h82, 8'h02, 8'h83, 8'h03, 8'h84};
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			token_ep_addr <= ea[i];
			@(posedge pclk);
			#1;
			chk("ep", i < 7 ? {1'b1, i[2:0]} : 0, {token_ep_valid, token_pipe});
		end
	endtask
	task t_clk;
		@(posedge pclk);
		usb_clk_running <= 0;
		repeat (2) @(posedge pclk);
		#1;
		chk("xcvr", 0, xcvr_enable);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		usb_clk_running <= 1;
		vbus_on <= 1;
		t_regs;
		t_speed;
		t_test;
		t_tok;
		t_clk;
		give_verdict;
	end
endmodule // testbench
